//--- verilog/ospc_pkg.sv
/*
 * Shared constants and types of the one-shot pulse channel: register
 * offsets, control field layout, reset values and the phase encoding.
 * Assumes a plain register port with 8-bit byte addresses and 32-bit data.
 */
package ospc_pkg;

   // Widths
   localparam int unsigned OSPC_AW = 8;
   localparam int unsigned OSPC_DW = 32;
   localparam int unsigned OSPC_CW = 16;

   // Register byte offsets
   localparam logic [7:0] OSPC_OFS_CTRL = 8'h00;
   localparam logic [7:0] OSPC_OFS_COUNTER = 8'h04;
   localparam logic [7:0] OSPC_OFS_PERIOD = 8'h08;
   localparam logic [7:0] OSPC_OFS_DUTY = 8'h0c;
   localparam logic [7:0] OSPC_OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OSPC_OFS_IRQ_FLAGS = 8'h14;
   localparam logic [7:0] OSPC_OFS_STATUS = 8'h18;

   // Control field positions
   localparam int unsigned OSPC_CTRL_ENABLE_POS = 0;
   localparam int unsigned OSPC_CTRL_OSM_POS = 1;
   localparam int unsigned OSPC_CTRL_TRIG_POS = 2;
   localparam int unsigned OSPC_CTRL_UD_POS = 3;
   localparam int unsigned OSPC_CTRL_CLK_POS = 5;
   localparam int unsigned OSPC_CTRL_RST_POS = 8;
   localparam int unsigned OSPC_CTRL_BITS = 8;

   // Interrupt flag positions
   localparam int unsigned OSPC_IRQ_PERIOD_POS = 0;
   localparam int unsigned OSPC_IRQ_DUTY_POS = 1;

   // Reset values
   localparam logic [15:0] OSPC_COUNTER_RST = 16'h0000;
   localparam logic [15:0] OSPC_PERIOD_RST = 16'hffff;
   localparam logic [15:0] OSPC_DUTY_RST = 16'h0000;
   localparam logic [1:0] OSPC_IRQ_RST = 2'h0;
   localparam logic [31:0] OSPC_RDATA_RST = 32'h0000_0000;

   // Control register, stored bits only (channel reset is a strobe)
   typedef struct packed {
      logic [2:0] clk_sel;
      logic [1:0] updown_count_select;
      logic one_shot_trigger_start;
      logic one_shot_enable;
      logic enable;
   } ospc_ctrl_type;

   localparam ospc_ctrl_type OSPC_CTRL_RST = '0;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ospc_bus_req_type;

   // Channel output group
   typedef struct packed {
      logic channel_out;
      logic pattern_engine_output;
      logic period_compare_trigger;
      logic duty_compare_trigger;
   } ospc_out_type;

   // Counting phases
   typedef enum logic [1:0] {
      OSPC_PH_IDLE,
      OSPC_PH_INITIAL,
      OSPC_PH_ACTIVE,
      OSPC_PH_CONT
   } ospc_phase_type;

endpackage

//--- verilog/ospc_clock_enable.sv
/*
 * Counter clock enable for the pulse channel: a free running divider of
 * the module clock, with one of eight power-of-two rates selected.
 * Assumes the select field is steady while the channel runs.
 */
`timescale 1ns/1ps
`default_nettype none

module ospc_clock_enable (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Rate select, divide by two to the power of sel
   input wire logic [2:0] clk_sel,
   // One-cycle enable pulse
   output logic fixed_clock_enable
);
   import ospc_pkg::*;

   logic [7:0] div_r;
   logic [7:0] div_nxt;
   logic [7:0] mask;
   logic tick_nxt;

   // Mask of the low divider bits that must all be zero for a tick
   assign mask = 8'((9'h1 << clk_sel) - 9'h1);
   assign div_nxt = div_r + 8'h01;
   assign tick_nxt = (div_r & mask) == 8'h00;

   // Divider and registered enable; the enable lags the divider by a cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         div_r <= 8'h00;
         fixed_clock_enable <= 1'b0;
      end else begin
         div_r <= div_nxt;
         fixed_clock_enable <= tick_nxt;
      end
   end

endmodule

`default_nettype wire

//--- verilog/ospc_channel.sv
/*
 * One-shot pulse channel of a timer output module in signal output PWM
 * mode, with its register port, compare units, trigger start inputs and
 * pattern engine output.
 * Assumes a single 40 MHz clock, a synchronous active-high reset, a
 * register master that never issues read and write together, and a
 * chain trigger produced by logic on the same clock.
 * The counter clock enable comes from a local divider, so the compare
 * units act only on cycles where that enable is high.
 */
// How it works
// - A counter write starts a one-shot sequence when trigger start is off.
// - After a write start the output stays inactive for period minus start.
// - At period minus one: active edge, counter cleared, counting resumes.
// - In the active pulse, duty minus one gives the inactive edge and ends.
// - Both compare units also compare and trigger in the initial phase.
// - Enabled compare triggers set their flag and raise the interrupt.
// - With trigger start, chain or capture trigger starts, counter cleared.
// - A trigger-started initial phase ends at period minus one from zero.
// - Later write-started pulses still emit the initial-phase triggers their start value reaches.
// - Duty one with trigger start: trigger in initial phase, another at the inactive edge.
`timescale 1ns/1ps
`default_nettype none

module ospc_channel (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire ospc_pkg::ospc_bus_req_type bus_req,
   output logic [31:0] bus_rdata,
   // Trigger start sources
   input wire logic chain_trigger_in,
   input wire logic external_capture_event,
   // Channel outputs
   output ospc_pkg::ospc_out_type chan_out,
   output logic channel_irq
);
   import ospc_pkg::*;

   // Compare match: counter equals compare value minus one, in counter width
   function automatic logic cmp_match(input logic [15:0] cnt,
                                      input logic [15:0] cmp);
      cmp_match = cnt == 16'(cmp - 16'h0001);
   endfunction

   // Register state
   ospc_ctrl_type ctrl_r;
   logic [15:0] period_compare_r;
   logic [15:0] duty_compare_r;
   logic [1:0] irq_en_r;
   logic [1:0] irq_en_nxt;
   logic [1:0] channel_irq_flags_r;
   logic [1:0] channel_irq_flags_nxt;

   // Channel state
   ospc_phase_type phase_r;
   ospc_phase_type phase_nxt;
   logic [15:0] channel_counter_r;
   logic [15:0] channel_counter_nxt;
   logic out_level_r;
   logic out_level_nxt;
   logic period_trig_nxt;
   logic duty_trig_nxt;

   // Capture event synchroniser and edge detector
   logic ext_meta_r;
   logic ext_sync_r;
   logic ext_prev_r;
   logic ext_edge;

   // Clock enable from the divider
   logic fixed_clock_enable;

   // Address decode
   logic hit_ctrl;
   logic hit_counter;
   logic hit_period;
   logic hit_duty;
   logic hit_irq_en;
   logic hit_flags;
   logic hit_status;
   logic wr_ctrl;
   logic wr_counter;
   logic chan_reset;
   logic [31:0] rdata_nxt;

   // Start and compare events
   logic start_write;
   logic start_trig;
   logic stop_now;
   logic running;
   logic period_hit;
   logic duty_hit;
   logic [1:0] trig_vec;
   logic [1:0] flag_clear;
   logic [31:0] status_word;

   ospc_clock_enable u_clock_enable (
      .clk(clk),
      .srst(srst),
      .clk_sel(ctrl_r.clk_sel),
      .fixed_clock_enable(fixed_clock_enable)
   );

   // Address decode of the register port
   // Decoding is exact on the byte address; unaligned ones hit nothing
   assign hit_ctrl = bus_req.addr == OSPC_OFS_CTRL;
   assign hit_counter = bus_req.addr == OSPC_OFS_COUNTER;
   assign hit_period = bus_req.addr == OSPC_OFS_PERIOD;
   assign hit_duty = bus_req.addr == OSPC_OFS_DUTY;
   assign hit_irq_en = bus_req.addr == OSPC_OFS_IRQ_EN;
   assign hit_flags = bus_req.addr == OSPC_OFS_IRQ_FLAGS;
   assign hit_status = bus_req.addr == OSPC_OFS_STATUS;
   assign wr_ctrl = bus_req.wr && hit_ctrl;
   assign wr_counter = bus_req.wr && hit_counter;

   // Channel reset strobe; the other bits of the same word are still stored in ctrl_r
   assign chan_reset = wr_ctrl && bus_req.wdata[OSPC_CTRL_RST_POS];

   // Writing enable low stops the channel in the cycle of the write, like
   // the reset strobe, so no edge slips out after software has disabled it
   assign stop_now = wr_ctrl && !bus_req.wdata[OSPC_CTRL_ENABLE_POS];

   // Write one to clear on the flag register
   assign flag_clear = (bus_req.wr && hit_flags) ? bus_req.wdata[1:0] :
                       2'h0;

   // Interrupt enable as it stands after this cycle's write; the interrupt
   // line follows a new mask at once rather than a cycle late
   assign irq_en_nxt = (bus_req.wr && hit_irq_en) ? bus_req.wdata[1:0] :
                       irq_en_r;

   // Read-back word of the channel state
   assign status_word = {13'h0000, out_level_r, phase_r, channel_counter_r};

   // Read data selection, unmapped addresses read as zero
   always_comb begin
      if (hit_ctrl) begin
         rdata_nxt = {24'h000000, ctrl_r};
      end else if (hit_counter) begin
         rdata_nxt = {16'h0000, channel_counter_r};
      end else if (hit_period) begin
         rdata_nxt = {16'h0000, period_compare_r};
      end else if (hit_duty) begin
         rdata_nxt = {16'h0000, duty_compare_r};
      end else if (hit_irq_en) begin
         rdata_nxt = {30'h00000000, irq_en_r};
      end else if (hit_flags) begin
         rdata_nxt = {30'h00000000, channel_irq_flags_r};
      end else if (hit_status) begin
         rdata_nxt = status_word;
      end else begin
         rdata_nxt = OSPC_RDATA_RST;
      end
   end

   // Edge of the synchronised capture input, never of the first stage
   assign ext_edge = ext_sync_r && !ext_prev_r;

   // Start conditions; the mode bits pick which source may start
   // A chain trigger is a level: held high it restarts every cycle
   assign start_write = wr_counter && ctrl_r.enable && ctrl_r.one_shot_enable
                        && !ctrl_r.one_shot_trigger_start;
   assign start_trig = ctrl_r.enable && ctrl_r.one_shot_enable &&
                       ctrl_r.one_shot_trigger_start &&
                       (chain_trigger_in || ext_edge);

   // Compare units run in every counting phase, the initial one included
   // Matching at compare minus one lets the wrap land on the period count
   assign running = phase_r != OSPC_PH_IDLE;
   assign period_hit = running && fixed_clock_enable &&
                       cmp_match(channel_counter_r, period_compare_r);
   assign duty_hit = running && fixed_clock_enable &&
                     cmp_match(channel_counter_r, duty_compare_r);

   // Next counter, phase and level of the channel
   always_comb begin
      phase_nxt = phase_r;
      channel_counter_nxt = channel_counter_r;
      out_level_nxt = out_level_r;
      period_trig_nxt = 1'b0;
      duty_trig_nxt = 1'b0;
      if (chan_reset || stop_now || !ctrl_r.enable) begin
         // Disabled or reset: stop and hold the line inactive
         phase_nxt = OSPC_PH_IDLE;
         out_level_nxt = 1'b0;
         if (chan_reset) begin
            channel_counter_nxt = OSPC_COUNTER_RST;
         end else if (wr_counter) begin
            channel_counter_nxt = bus_req.wdata[15:0];
         end
      end else if (start_write) begin
         // Fresh start from the written value; no compare history is kept,
         // so every restart behaves like the first one
         phase_nxt = OSPC_PH_INITIAL;
         channel_counter_nxt = bus_req.wdata[15:0];
         out_level_nxt = 1'b0;
      end else if (start_trig) begin
         phase_nxt = OSPC_PH_INITIAL;
         channel_counter_nxt = OSPC_COUNTER_RST;
         out_level_nxt = 1'b0;
      end else if (wr_counter) begin
         // Plain load outside a start
         channel_counter_nxt = bus_req.wdata[15:0];
      end else if (phase_r == OSPC_PH_IDLE) begin
         // Continuous mode starts as soon as one-shot is off
         if (!ctrl_r.one_shot_enable) begin
            phase_nxt = OSPC_PH_CONT;
         end
      end else if (fixed_clock_enable) begin
         // Triggers come from the same match terms in every phase, so a
         // start value past a compare point only skips that match in this
         // shot and never hides it in a later one
         period_trig_nxt = period_hit;
         duty_trig_nxt = duty_hit;
         if (period_hit) begin
            // Period wrap: counter to zero, active edge from the initial or continuous phase
            channel_counter_nxt = OSPC_COUNTER_RST;
            if (phase_r == OSPC_PH_INITIAL) begin
               phase_nxt = OSPC_PH_ACTIVE;
               out_level_nxt = 1'b1;
            end else if (phase_r == OSPC_PH_ACTIVE) begin
               // Duty beyond the period: the pulse ends at the period
               phase_nxt = OSPC_PH_IDLE;
               out_level_nxt = 1'b0;
            end else begin
               out_level_nxt = 1'b1;
            end
         end else begin
            channel_counter_nxt = 16'(channel_counter_r + 16'h0001);
         end
         if (duty_hit && phase_r == OSPC_PH_ACTIVE) begin
            // Inactive edge ends the shot; the counter stops, so a duty of
            // one cannot match again when the period comes round
            phase_nxt = OSPC_PH_IDLE;
            out_level_nxt = 1'b0;
            channel_counter_nxt = channel_counter_r;
         end else if (duty_hit && phase_r == OSPC_PH_CONT && !period_hit) begin
            out_level_nxt = 1'b0;
         end
         if (!ctrl_r.one_shot_enable && phase_r != OSPC_PH_CONT &&
             phase_nxt == OSPC_PH_IDLE) begin
            phase_nxt = OSPC_PH_CONT;
         end
      end
   end

   // Compare events as a vector in flag order
   assign trig_vec = {duty_trig_nxt, period_trig_nxt};

   // Flags: a trigger in the clearing cycle wins over the clear
   // A flag stays set until software writes a one to it
   assign channel_irq_flags_nxt = (channel_irq_flags_r & ~flag_clear) |
                                  (trig_vec & irq_en_r);

   // Register writes; compare values may change while counting and
   // take effect at the next tick, with no shadow copy
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= OSPC_CTRL_RST;
         period_compare_r <= OSPC_PERIOD_RST;
         duty_compare_r <= OSPC_DUTY_RST;
         irq_en_r <= OSPC_IRQ_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ospc_ctrl_type'(bus_req.wdata[OSPC_CTRL_BITS-1:0]);
         end
         if (bus_req.wr && hit_period) begin
            period_compare_r <= bus_req.wdata[15:0];
         end
         if (bus_req.wr && hit_duty) begin
            duty_compare_r <= bus_req.wdata[15:0];
         end
         if (bus_req.wr && hit_irq_en) begin
            irq_en_r <= bus_req.wdata[1:0];
         end
      end
   end

   // Read data stands one cycle after the read strobe only
   // Zero between reads lets several banks be ORed onto one bus
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_rdata <= OSPC_RDATA_RST;
      end else begin
         bus_rdata <= bus_req.rd ? rdata_nxt : OSPC_RDATA_RST;
      end
   end

   // Two-stage synchroniser for the capture pin, then the edge history
   // The first stage may go metastable, so only the second one is read
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end else begin
         ext_meta_r <= external_capture_event;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   // Channel state registers
   // Flags sit beside the phase so set and clear resolve in one place
   always_ff @(posedge clk) begin
      if (srst) begin
         phase_r <= OSPC_PH_IDLE;
         channel_counter_r <= OSPC_COUNTER_RST;
         out_level_r <= 1'b0;
         channel_irq_flags_r <= OSPC_IRQ_RST;
      end else begin
         phase_r <= phase_nxt;
         channel_counter_r <= channel_counter_nxt;
         out_level_r <= out_level_nxt;
         channel_irq_flags_r <= channel_irq_flags_nxt;
      end
   end

   // Outputs; the pattern engine copy is dead in up/down mode
   // Next-state values are registered so each pin is a flop in step
   always_ff @(posedge clk) begin
      if (srst) begin
         chan_out <= '0;
         channel_irq <= 1'b0;
      end else begin
         chan_out.channel_out <= out_level_nxt;
         chan_out.pattern_engine_output <= out_level_nxt &&
            (ctrl_r.updown_count_select == 2'h0);
         chan_out.period_compare_trigger <= period_trig_nxt;
         chan_out.duty_compare_trigger <= duty_trig_nxt;
         channel_irq <= |(channel_irq_flags_nxt & irq_en_nxt);
      end
   end

endmodule

`default_nettype wire

//--- verif/ospc_channel_properties.sv
/* Port checker of the pulse channel.
   Bound to ospc_channel; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ospc_channel_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire ospc_pkg::ospc_bus_req_type bus_req,
   input wire logic [31:0] bus_rdata,
   // Trigger inputs
   input wire logic chain_trigger_in,
   input wire logic external_capture_event,
   // Outputs
   input wire ospc_pkg::ospc_out_type chan_out,
   input wire logic channel_irq
);
   import ospc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic per_t = chan_out.period_compare_trigger;
   wire logic dut_t = chan_out.duty_compare_trigger;
   wire logic out_l = chan_out.channel_out;
   // A level move needs a compare hit or a register write
   sequence s_cause;
      per_t || dut_t || $past(bus_req.wr);
   endsequence
   sequence s_irq_cause;
      per_t || dut_t || $past(per_t) || $past(dut_t) || $past(bus_req.wr);
   endsequence
   out_rise_a: assert property ($rose(out_l) |-> per_t)
      else $error("output rose without period hit");
   out_change_a: assert property ($changed(out_l) |-> s_cause)
      else $error("output moved without cause");
   period_high_a: assert property (per_t && !$past(out_l) |-> out_l)
      else $error("period hit left output low");
   duty_end_a: assert property (dut_t && !per_t && $past(out_l) |-> !out_l)
      else $error("duty hit did not end pulse");
   duty_quiet_a: assert property (dut_t && !per_t && !$past(out_l) |-> !out_l)
      else $error("initial duty hit raised output");
   pattern_copy_a: assert property (chan_out.pattern_engine_output |-> out_l)
      else $error("pattern output without channel output");
   rdata_idle_a: assert property (bus_rdata != 32'h0 |-> $past(bus_req.rd))
      else $error("read data outside read slot");
   irq_raise_a: assert property ($rose(channel_irq) |-> s_irq_cause)
      else $error("interrupt without trigger");
   irq_drop_a: assert property ($fell(channel_irq) |-> $past(bus_req.wr))
      else $error("interrupt dropped without write");
   cover property (chain_trigger_in);
endmodule
bind ospc_channel ospc_channel_chk u_chk (.clk(clk), .srst(srst),
   .bus_req(bus_req), .bus_rdata(bus_rdata),
   .chain_trigger_in(chain_trigger_in),
   .external_capture_event(external_capture_event),
   .chan_out(chan_out), .channel_irq(channel_irq));
`default_nettype wire

//--- verif/ospc_pin_model.sv
/* Pin side and pattern engine model: measures each pulse.
   Assumes arm is raised in the cycle a start is requested. */
`timescale 1ns/1ps
`default_nettype none
module ospc_pin_model (
   // Clock, reset, measurement restart
   input wire logic clk,
   input wire logic srst,
   input wire logic arm,
   // Channel outputs at the pins
   input wire ospc_pkg::ospc_out_type chan_out,
   // Measurements of the latest pulse
   output logic [31:0] rise_at,
   output logic [31:0] high_len,
   output logic [31:0] n_period,
   output logic [31:0] n_duty,
   output logic done,
   output logic pe_bad
);
   import ospc_pkg::*;
   logic [31:0] cnt_r;
   logic seen_r;
   // Counts run from the start edge; restart drops history
   always_ff @(posedge clk) begin
      if (srst || arm) begin
         cnt_r <= '0;
         rise_at <= '0;
         high_len <= '0;
         n_period <= '0;
         n_duty <= '0;
         done <= 1'b0;
         seen_r <= 1'b0;
         pe_bad <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         n_period <= n_period + 32'(chan_out.period_compare_trigger);
         n_duty <= n_duty + 32'(chan_out.duty_compare_trigger);
         if (chan_out.channel_out) begin
            high_len <= high_len + 32'h1;
            seen_r <= 1'b1;
            if (!seen_r) rise_at <= cnt_r;
         end
         if (seen_r && !chan_out.channel_out) done <= 1'b1;
         // Engine needs the copy while counting up only
         if (chan_out.pattern_engine_output !== chan_out.channel_out)
            pe_bad <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- verif/one_shot_pulse_channel_tb_top.sv
/* Self-checking bench of the one-shot pulse channel.
   Assumes checker bind and pin model are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module one_shot_pulse_channel_tb_top;
   import ospc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   ospc_bus_req_type bus_req = '0;
   logic chain_trigger_in = 1'b0;
   logic external_capture_event = 1'b0;
   logic arm = 1'b0;
   logic [31:0] bus_rdata;
   ospc_out_type chan_out;
   logic channel_irq;
   logic [31:0] rise_at, high_len, n_period, n_duty;
   logic done, pe_bad;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   int p, d, m, n;
   logic [7:0] ra [7] = '{OSPC_OFS_CTRL, OSPC_OFS_COUNTER, OSPC_OFS_PERIOD,
      OSPC_OFS_DUTY, OSPC_OFS_IRQ_EN, OSPC_OFS_IRQ_FLAGS, 8'h1c};
   logic [31:0] rv [7] = '{{24'h0, OSPC_CTRL_RST}, 32'(OSPC_COUNTER_RST),
      32'(OSPC_PERIOD_RST), 32'(OSPC_DUTY_RST), 32'(OSPC_IRQ_RST),
      32'(OSPC_IRQ_RST), 32'h0};
   always #12.5 clk = ~clk;
   ospc_channel uut (.clk(clk), .srst(srst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .chain_trigger_in(chain_trigger_in),
      .external_capture_event(external_capture_event),
      .chan_out(chan_out), .channel_irq(channel_irq));
   ospc_pin_model far (.clk(clk), .srst(srst), .arm(arm),
      .chan_out(chan_out), .rise_at(rise_at), .high_len(high_len),
      .n_period(n_period), .n_duty(n_duty), .done(done), .pe_bad(pe_bad));
   task give_verdict();
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.wdata <= v;
      bus_req.wr <= 1'b1;
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1 check(bus_rdata, exp);
   endtask
   // Duty hit in the quiet phase only if the count passes it
   function automatic logic [31:0] exp_duty(int sn, int sd);
      return (sn <= sd - 1) ? 32'h2 : 32'h1;
   endfunction
   function automatic logic [31:0] exp_rise(int sn, int sp);
      return 32'(sp - sn);
   endfunction
   // mode 0 write, 1 zero then value, 2 chain, 3 capture
   task automatic shot(int sn, int sp, int sd, int sel, int mask, int mode,
                       bit rs);
      logic [31:0] ctl;
      ctl = 32'((sel << 5) | ((mode >= 2) << 2) | 3);
      bus_wr(OSPC_OFS_PERIOD, 32'(sp));
      bus_wr(OSPC_OFS_DUTY, 32'(sd));
      bus_wr(OSPC_OFS_IRQ_EN, 32'(mask));
      bus_wr(OSPC_OFS_CTRL, ctl);
      if (mode == 1) bus_wr(OSPC_OFS_COUNTER, 32'h0);
      @(posedge clk);
      arm <= 1'b1;
      if (mode < 2) begin
         bus_req.addr <= OSPC_OFS_COUNTER;
         bus_req.wdata <= 32'(sn);
         bus_req.wr <= 1'b1;
      end else if (mode == 2) chain_trigger_in <= 1'b1;
      else external_capture_event <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      bus_req.wr <= 1'b0;
      chain_trigger_in <= 1'b0;
      repeat (4000) begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      external_capture_event <= 1'b0;
      #1;
      if (sel == 0 && mode != 3) check(rise_at, exp_rise(sn, sp));
      check(high_len, 32'(sd << sel));
      check(n_period, 32'h1);
      check(n_duty, exp_duty(sn, sd));
      check({31'h0, pe_bad}, 32'h0);
      rd_chk(OSPC_OFS_STATUS, 32'(sd - 1));
      rd_chk(OSPC_OFS_IRQ_FLAGS, 32'(mask));
      check({31'h0, channel_irq}, 32'(mask != 0));
      bus_wr(OSPC_OFS_IRQ_FLAGS, 32'h3);
      @(posedge clk);
      #1 check({31'h0, channel_irq}, 32'h0);
      if (rs) bus_wr(OSPC_OFS_CTRL, 32'h100);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'h88b24f37));
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
      shot(7, 8, 3, 0, 3, 0, 0);
      shot(7, 8, 3, 0, 3, 0, 0);
      shot(2, 8, 3, 0, 1, 0, 0);
      shot(4, 9, 2, 0, 2, 1, 1);
      shot(0, 6, 1, 0, 3, 2, 0);
      shot(0, 6, 1, 0, 3, 3, 1);
      shot(1, 5, 2, 2, 3, 0, 1);
      for (int i = 0; i < 8; i++) begin
         p = 3 + int'($urandom % 12);
         d = 1 + int'($urandom % (p - 1));
         m = int'($urandom % 4);
         n = (m >= 2) ? 0 : int'($urandom % p);
         shot(n, p, d, int'($urandom % 2), int'($urandom % 4), m, 1'($urandom));
      end
      // Continuous mode: reset with enable, phase leaves idle a cycle later
      bus_wr(OSPC_OFS_CTRL, 32'h101);
      rd_chk(OSPC_OFS_STATUS,
             {14'h0, 2'(OSPC_PH_CONT), OSPC_COUNTER_RST});
      give_verdict();
   end
endmodule
`default_nettype wire
